// ==== acr_pkg.sv ====
`default_nettype none
package acr_pkg;
    localparam int ADDR_W = 12;
    localparam logic [9:0] IDX_MISC = 10'h077;
    localparam logic [9:0] IDX_RES_LO = 10'h078;
    localparam logic [9:0] IDX_RES_HI = 10'h079;
    localparam logic [9:0] IDX_CSA = 10'h07a;
    localparam logic [9:0] IDX_CSB = 10'h07b;
    localparam logic [9:0] IDX_SEL = 10'h07c;
    localparam int CSA_EN = 7;
    localparam int CSA_SC = 6;
    localparam int CSA_ATE = 5;
    localparam int CSA_IF = 4;
    localparam int CSA_IE = 3;
    localparam int SEL_LAR = 5;
    localparam int MISC_EXT = 2;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [4:0] LEN_NORMAL = 5'h0d;
    localparam logic [4:0] LEN_EXT = 5'h19;
    localparam logic [2:0] DIV_MIN_CODE = 3'h2;
    localparam logic [2:0] TRIG_FREE = 3'h0;
    localparam logic [1:0] REF_AVCC = 2'h0;
    localparam logic [1:0] REF_PIN = 2'h1;
    localparam logic [1:0] REF_1V1 = 2'h2;
    localparam logic [1:0] REF_2V56 = 2'h3;
    localparam logic [2:0] SRC_PIN = 3'h0;
    localparam logic [2:0] SRC_TEMP = 3'h1;
    localparam logic [2:0] SRC_BANDGAP = 3'h2;
    localparam logic [2:0] SRC_QUARTER = 3'h3;
    localparam logic [2:0] SRC_GROUND = 3'h4;
    localparam logic [2:0] SRC_RSVD = 3'h5;
    localparam logic [2:0] SRC_DIFF = 3'h6;
    localparam logic [3:0] CH_LAST_PIN = 4'ha;
    localparam logic [3:0] CH_TEMP = 4'hb;
    localparam logic [3:0] CH_BANDGAP = 4'hc;
    localparam logic [3:0] CH_QUARTER = 4'hd;
    localparam logic [3:0] CH_GROUND = 4'he;
    localparam logic [2:0] DIFF_SKIP1 = 3'h3;
    localparam logic [2:0] DIFF_SKIP2 = 3'h6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ACR_IDLE = 2'b01,
        ACR_CONV = 2'b10
    } acr_state_t;
endpackage
`default_nettype wire

// ==== acr_control.sv ====
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// How it works
// RULE_01: reference change mid-conversion waits until that conversion completes
// RULE_02: conversion after any reference change is extended to 25 ticks; code extends only after select bits 7:6 change, not the external enable
// RULE_03: reference from select bits plus external enable: supply, pin, 1.1V, 2.56V
// RULE_04: adjust bit one gives left adjusted data, zero right adjusted
// RULE_05: adjust bit changes the data presentation immediately
// RULE_06: channel select change mid-conversion waits until that conversion completes
// RULE_07: codes 0..10 single pins, then temp, bandgap, quarter supply, ground, reserved
// RULE_08: top bit set selects differential pairs, low bit gives 8x or 20x
// RULE_09: enable one powers on, zero powers off and aborts a conversion
// RULE_10: start write launches one conversion, or the first in free running
// RULE_11: first conversion after enabling takes 25 ticks, others 13
// RULE_12: start bit reads one while converting, writing zero does nothing
// RULE_13: auto-trigger starts a conversion on each rising edge of selected trigger
// RULE_14: done flag sets when conversion ends and result is stored
// RULE_15: interrupt request when flag, enable and global enable are set
// RULE_16: flag clears on vector execution or on writing one
// RULE_17: software read-modify-write of a set flag clears it
// RULE_18: converter tick divides system clock by 2,2,4,8..128
// RULE_19: after low byte read, result held until high byte read
// RULE_20: trigger code zero free running, others pick external trigger lines
// RULE_21: bit placement of the 10-bit result in high and low bytes
// RULE_22: free running restarts at each completion while enabled
// RULE_23: prescaler counts only while enabled, restarting from zero
module acr_control (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [9:0] convResult,
    input wire logic [6:0] triggerIn,
    input wire logic globalIrqEnable,
    input wire logic irqVectorTaken,
    output logic converterTick,
    output logic conversionActive,
    output logic conversionStart,
    output logic extendedConversion,
    output logic [1:0] referenceKind,
    output logic [2:0] sourceKind,
    output logic [3:0] channelPos,
    output logic [3:0] channelNeg,
    output logic gainHigh,
    output logic conversionIrq
);
    acr_pkg::acr_state_t state;
    logic wrReady, rdReady, bValid, rValid;
    logic [1:0] bResp, rResp;
    logic [31:0] rData;
    logic [7:0] selReg;
    logic converterEnable, autoTrig, doneFlag, irqEnable, extRefEnable;
    logic [2:0] divSel, trigSrc;
    logic [7:0] appliedSel;
    logic appliedExt;
    logic [6:0] divCount;
    logic [4:0] convCount;
    logic convExt, firstPending, refChanged, trigPrev, resultLock;
    logic [9:0] resultValue;
    logic [9:0] widx, ridx;
    logic wrFire, rdFire, wrCsa, wrSel, disableWr, enableRise, swStart;
    logic trigSel, trigEdge, finish, startNow, extNow, busy;
    logic [7:0] wByte, divFull, rdByte;
    logic [6:0] divLimit;
    logic [4:0] convLen;
    logic rdMapped, wrMapped;

    assign s_axi_awready = wrReady;
    assign s_axi_wready = wrReady;
    assign s_axi_bvalid = bValid;
    assign s_axi_bresp = bResp;
    assign s_axi_arready = rdReady;
    assign s_axi_rvalid = rValid;
    assign s_axi_rresp = rResp;
    assign s_axi_rdata = rData;
    // one-hot state bit, so this is a flop
    assign conversionActive = state[1];
    assign busy = state[1];

    assign widx = s_axi_awaddr[acr_pkg::ADDR_W-1:2];
    assign ridx = s_axi_araddr[acr_pkg::ADDR_W-1:2];
    assign wByte = s_axi_wdata[7:0];
    assign wrFire = wrReady & s_axi_awvalid & s_axi_wvalid;
    assign rdFire = rdReady & s_axi_arvalid;
    // data sits in lane 0 only; other lanes ignored
    assign wrCsa = wrFire & s_axi_wstrb[0] & (widx == acr_pkg::IDX_CSA);
    assign wrSel = wrFire & s_axi_wstrb[0] & (widx == acr_pkg::IDX_SEL);
    assign disableWr = wrCsa & ~wByte[acr_pkg::CSA_EN];
    assign enableRise = wrCsa & wByte[acr_pkg::CSA_EN] & ~converterEnable;
    assign swStart = wrCsa & wByte[acr_pkg::CSA_EN] & wByte[acr_pkg::CSA_SC]; // RULE_10 RULE_12
    assign wrMapped = (widx >= acr_pkg::IDX_MISC) && (widx <= acr_pkg::IDX_SEL);
    assign rdMapped = (ridx >= acr_pkg::IDX_MISC) && (ridx <= acr_pkg::IDX_SEL);

    // bus write: both channels taken in the same cycle
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            wrReady <= 1'b0;
            bValid <= 1'b0;
            bResp <= acr_pkg::RESP_OKAY;
        end
        else
        begin
            wrReady <= ~wrReady & s_axi_awvalid & s_axi_wvalid & ~bValid;
            if (wrFire)
            begin
                bValid <= 1'b1;
                bResp <= wrMapped ? acr_pkg::RESP_OKAY : acr_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                bValid <= 1'b0;
        end
    end

    // register read bytes; adjust applied at read time so it acts at once
    always_comb
    begin
        rdByte = acr_pkg::RESET_BYTE;
        unique case (ridx)
            acr_pkg::IDX_SEL: rdByte = selReg;
            acr_pkg::IDX_CSA: rdByte = {converterEnable, busy, autoTrig, doneFlag, irqEnable, divSel}; // RULE_12
            acr_pkg::IDX_CSB: rdByte = {5'h00, trigSrc};
            acr_pkg::IDX_MISC: rdByte = {5'h00, extRefEnable, 2'h0};
            acr_pkg::IDX_RES_LO: rdByte = selReg[acr_pkg::SEL_LAR] ? {resultValue[1:0], 6'h00}
                : resultValue[7:0]; // RULE_04 RULE_05 RULE_21
            acr_pkg::IDX_RES_HI: rdByte = selReg[acr_pkg::SEL_LAR] ? resultValue[9:2]
                : {6'h00, resultValue[9:8]}; // RULE_04 RULE_05 RULE_21
            default: rdByte = acr_pkg::RESET_BYTE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            rdReady <= 1'b0;
            rValid <= 1'b0;
            rResp <= acr_pkg::RESP_OKAY;
            rData <= 32'h00000000;
        end
        else
        begin
            rdReady <= ~rdReady & s_axi_arvalid & ~rValid;
            if (rdFire)
            begin
                rValid <= 1'b1;
                rResp <= rdMapped ? acr_pkg::RESP_OKAY : acr_pkg::RESP_SLVERR;
                rData <= {24'h000000, rdByte};
            end
            else if (s_axi_rready)
                rValid <= 1'b0;
        end
    end

    // software-written control
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            selReg <= acr_pkg::RESET_BYTE;
            converterEnable <= 1'b0;
            autoTrig <= 1'b0;
            irqEnable <= 1'b0;
            divSel <= 3'h0;
            trigSrc <= acr_pkg::TRIG_FREE;
            extRefEnable <= 1'b0;
        end
        else
        begin
            if (wrSel)
                selReg <= wByte;
            if (wrCsa)
            begin
                converterEnable <= wByte[acr_pkg::CSA_EN]; // RULE_09
                autoTrig <= wByte[acr_pkg::CSA_ATE];
                irqEnable <= wByte[acr_pkg::CSA_IE];
                divSel <= wByte[2:0];
            end
            if (wrFire && s_axi_wstrb[0] && widx == acr_pkg::IDX_CSB)
                trigSrc <= wByte[2:0];
            if (wrFire && s_axi_wstrb[0] && widx == acr_pkg::IDX_MISC)
                extRefEnable <= wByte[acr_pkg::MISC_EXT];
        end
    end

    // prescaler; held at zero while off so enabling restarts it
    assign divFull = 8'h01 << divSel;
    assign divLimit = (divSel < acr_pkg::DIV_MIN_CODE) ? 7'h01 : 7'(divFull - 8'h01); // RULE_18
    always_ff @(posedge clk)
    begin
        if (!reset_n || !converterEnable)
        begin
            divCount <= 7'h00; // RULE_23
            converterTick <= 1'b0;
        end
        else
        begin
            converterTick <= (divCount == divLimit); // RULE_18
            divCount <= (divCount == divLimit) ? 7'h00 : 7'(divCount + 7'h01);
        end
    end

    // triggers; switching sources can itself make an edge
    assign trigSel = (trigSrc == acr_pkg::TRIG_FREE) ? 1'b0 : triggerIn[trigSrc - 3'h1]; // RULE_20
    assign trigEdge = trigSel & ~trigPrev;
    assign convLen = convExt ? acr_pkg::LEN_EXT : acr_pkg::LEN_NORMAL;
    assign finish = busy & converterTick & (convCount == 5'(convLen - 5'h01)) & ~disableWr;
    assign extNow = firstPending | refChanged | enableRise; // RULE_02 RULE_11
    // a start while converting is dropped, not queued
    assign startNow = (~busy | finish) & ~disableWr
        & (swStart // RULE_10
        | (converterEnable & autoTrig & trigEdge) // RULE_13
        | (converterEnable & finish & autoTrig & trigSrc == acr_pkg::TRIG_FREE)); // RULE_22

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            trigPrev <= 1'b0;
        else
            trigPrev <= trigSel;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state <= acr_pkg::ACR_IDLE;
            convCount <= 5'h00;
            convExt <= 1'b0;
            conversionStart <= 1'b0;
        end
        else
        begin
            conversionStart <= startNow;
            unique case (state)
                acr_pkg::ACR_IDLE:
                    if (startNow)
                    begin
                        state <= acr_pkg::ACR_CONV;
                        convCount <= 5'h00;
                        convExt <= extNow; // RULE_11
                    end
                acr_pkg::ACR_CONV:
                    if (disableWr)
                        state <= acr_pkg::ACR_IDLE; // RULE_09
                    else if (startNow)
                    begin
                        convCount <= 5'h00;
                        convExt <= extNow;
                    end
                    else if (finish)
                        state <= acr_pkg::ACR_IDLE;
                    else if (converterTick)
                        convCount <= 5'(convCount + 5'h01);
                default:
                    state <= acr_pkg::ACR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            firstPending <= 1'b0;
            refChanged <= 1'b0;
        end
        else
        begin
            if (startNow)
                firstPending <= 1'b0;
            else if (enableRise)
                firstPending <= 1'b1; // RULE_11
            // a change in the start cycle still counts for the next one
            if (wrSel && wByte[7:6] != selReg[7:6])
                refChanged <= 1'b1; // RULE_02
            else if (startNow)
                refChanged <= 1'b0;
        end
    end

    // selection follows the register only between conversions
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            appliedSel <= acr_pkg::RESET_BYTE;
            appliedExt <= 1'b0;
        end
        else if (!busy || finish)
        begin
            appliedSel <= selReg; // RULE_01 RULE_06
            appliedExt <= extRefEnable;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            referenceKind <= acr_pkg::REF_AVCC;
            sourceKind <= acr_pkg::SRC_PIN;
            channelPos <= 4'h0;
            channelNeg <= 4'h0;
            gainHigh <= 1'b0;
            extendedConversion <= 1'b0;
        end
        else
        begin
            extendedConversion <= convExt;
            if (appliedExt)
                referenceKind <= acr_pkg::REF_PIN; // RULE_03
            else if (!appliedSel[6])
                referenceKind <= acr_pkg::REF_AVCC;
            else
                referenceKind <= appliedSel[7] ? acr_pkg::REF_2V56 : acr_pkg::REF_1V1;
            gainHigh <= appliedSel[4] & appliedSel[0]; // RULE_08
            if (appliedSel[4])
            begin
                sourceKind <= acr_pkg::SRC_DIFF;
                channelPos <= 4'({1'b0, appliedSel[3:1]} + (appliedSel[3:1] >= acr_pkg::DIFF_SKIP1)
                    + (appliedSel[3:1] >= acr_pkg::DIFF_SKIP2)); // RULE_08
                channelNeg <= 4'({1'b0, appliedSel[3:1]} + (appliedSel[3:1] >= acr_pkg::DIFF_SKIP1)
                    + (appliedSel[3:1] >= acr_pkg::DIFF_SKIP2) + 4'h1);
            end
            else
            begin
                channelPos <= appliedSel[3:0];
                channelNeg <= 4'h0;
                unique case (appliedSel[3:0]) // RULE_07
                    acr_pkg::CH_TEMP: sourceKind <= acr_pkg::SRC_TEMP;
                    acr_pkg::CH_BANDGAP: sourceKind <= acr_pkg::SRC_BANDGAP;
                    acr_pkg::CH_QUARTER: sourceKind <= acr_pkg::SRC_QUARTER;
                    acr_pkg::CH_GROUND: sourceKind <= acr_pkg::SRC_GROUND;
                    default: sourceKind <= (appliedSel[3:0] <= acr_pkg::CH_LAST_PIN) ? acr_pkg::SRC_PIN
                        : acr_pkg::SRC_RSVD;
                endcase
            end
        end
    end

    // result, its read lock, the done flag and the request
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            resultValue <= 10'h000;
            resultLock <= 1'b0;
            doneFlag <= 1'b0;
            conversionIrq <= 1'b0;
        end
        else
        begin
            // a result finishing while locked is lost, as the pair must match
            if (finish && !resultLock)
                resultValue <= convResult; // RULE_19
            if (rdFire && ridx == acr_pkg::IDX_RES_LO)
                resultLock <= 1'b1; // RULE_19
            else if (rdFire && ridx == acr_pkg::IDX_RES_HI)
                resultLock <= 1'b0;
            if (finish)
                doneFlag <= 1'b1; // RULE_14
            else if ((wrCsa && wByte[acr_pkg::CSA_IF]) || irqVectorTaken)
                doneFlag <= 1'b0; // RULE_16
            conversionIrq <= doneFlag & irqEnable & globalIrqEnable; // RULE_15
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_len_normal: assert property (startNow && !extNow |=> convLen == acr_pkg::LEN_NORMAL) // RULE_11
        else $error("normal conversion not 13 ticks");
    a_len_first: assert property (enableRise && swStart |=> convExt && busy) // RULE_11
        else $error("first conversion not extended");
    a_len_refchg: assert property (refChanged && startNow |=> convLen == acr_pkg::LEN_EXT) // RULE_02
        else $error("conversion after reference change not extended");
    a_ref_hold: assert property (busy && !finish |=> $stable(appliedSel[7:6])) // RULE_01
        else $error("reference changed during conversion");
    a_sel_hold: assert property (busy && !finish |=> $stable(appliedSel[4:0])) // RULE_06
        else $error("channel changed during conversion");
    a_off_aborts: assert property (disableWr |=> !busy ##1 !converterTick) // RULE_09
        else $error("disable did not abort");
    a_flag_set: assert property (finish |=> doneFlag ##1 conversionIrq == (irqEnable && globalIrqEnable)) // RULE_14
        else $error("done flag not set at completion");
    a_irq_gate: assert property (conversionIrq |-> $past(doneFlag && irqEnable && globalIrqEnable)) // RULE_15
        else $error("interrupt without cause");
    a_flag_clear: assert property (irqVectorTaken && !finish |=> !doneFlag) // RULE_16
        else $error("flag not cleared by vector");
    a_lock_hold: assert property (resultLock |=> $stable(resultValue)) // RULE_19
        else $error("result changed while locked");
    a_free_run: assert property (finish && autoTrig && trigSrc == acr_pkg::TRIG_FREE |=> busy) // RULE_22
        else $error("free running did not restart");
    a_trig_start: assert property (converterEnable && autoTrig && trigEdge && !busy && !disableWr // RULE_13
        |=> conversionStart)
        else $error("trigger edge did not start");
    a_tick_off: assert property (!converterEnable |=> !converterTick [*2]) // RULE_23
        else $error("tick while disabled");
    c_finish: cover property (finish);
    c_extended: cover property (startNow && extNow);
    c_lock_drop: cover property (finish && resultLock);
endmodule
`default_nettype wire

// ==== acr_core_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module acr_core_model (
    input wire logic clk,
    input wire logic active,
    input wire logic start,
    input wire logic tick,
    input wire logic [9:0] sampleIn,
    output logic [9:0] convResult,
    output logic [7:0] tickCount
);
    // plain always: the start value of the toggle is set at its declaration
    logic flip = 1'b0;
    always @(posedge clk)
    begin
        flip <= ~flip;
        if (start)
            tickCount <= {7'h0, tick};
        else if (active && tick)
            tickCount <= tickCount + 8'h01;
    end
    // idle output alternates between the inverted sample and the sample, so a stale capture looks right every other cycle
    assign convResult = active ? sampleIn : ~sampleIn ^ {10{flip}};
endmodule
`default_nettype wire

// ==== tb_adc_control_registers.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_adc_control_registers;
    localparam logic [9:0] MISC = acr_pkg::IDX_MISC;
    localparam logic [9:0] LO = acr_pkg::IDX_RES_LO;
    localparam logic [9:0] HI = acr_pkg::IDX_RES_HI;
    localparam logic [9:0] CSA = acr_pkg::IDX_CSA;
    localparam logic [9:0] CSB = acr_pkg::IDX_CSB;
    localparam logic [9:0] SEL = acr_pkg::IDX_SEL;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, referenceKind, rr;
    logic [9:0] convResult, res, res2;
    logic [9:0] sample = 10'h0;
    logic [6:0] triggerIn = 7'h0;
    logic globalIrqEnable = 1'b1, irqVectorTaken = 1'b0;
    logic converterTick, conversionActive, conversionStart, extendedConversion, gainHigh, conversionIrq;
    logic [2:0] sourceKind;
    logic [3:0] channelPos, channelNeg;
    logic [7:0] tickCount, rv;
    integer seed = 32'h1edc;
    int bad_count = 0, tests_run = 0, cyc = 0, lastTick = 0, gap = 0, tickNum = 0, startCount = 0, k, n, p;
    acr_control i_dut (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .convResult, .triggerIn, .globalIrqEnable, .irqVectorTaken, .converterTick,
        .conversionActive, .conversionStart, .extendedConversion, .referenceKind, .sourceKind,
        .channelPos, .channelNeg, .gainHigh, .conversionIrq);
    acr_core_model i_core (.clk, .active(conversionActive), .start(conversionStart), .tick(converterTick),
        .sampleIn(sample), .convResult, .tickCount);
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    task automatic complete_run();
        if (bad_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge clk); while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        rr = s_axi_bresp;
    endtask
    task automatic rd(input logic [9:0] idx);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        rr = s_axi_rresp;
        rv = s_axi_rdata[7:0];
    endtask
    task automatic rc(input logic [9:0] idx, input logic [7:0] e);
        rd(idx);
        chk("register", {rr, rv}, {2'b00, e});
    endtask
    task automatic idle();
        while (conversionActive === 1'b1) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (conversionStart === 1'b1)
            startCount <= startCount + 1;
        if (converterTick === 1'b1)
        begin
            gap <= cyc - lastTick;
            lastTick <= cyc;
            tickNum <= tickNum + 1;
        end
        if (cyc == 20000)
        begin
            bad_count++;
            complete_run();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        for (k = 0; k < 6; k++)
            rc(MISC + 10'(k), 8'h00);
        rd(10'h004);
        chk("read resp", rr, acr_pkg::RESP_SLVERR);
        wr(10'h004, 8'h01);
        chk("write resp", rr, acr_pkg::RESP_SLVERR);
        s_axi_wstrb <= 4'h0;
        wr(SEL, 8'hff);
        s_axi_wstrb <= 4'hf;
        rc(SEL, 8'h00);
        for (k = 0; k < 8; k++)
        begin
            wr(CSA, 8'h80 | 8'(k));
            n = tickNum;
            while (tickNum < n + 3) @(posedge clk);
            chk("tick gap", gap, (k < 2) ? 2 : (1 << k));
        end
        wr(CSA, 8'h00);
        n = tickNum;
        repeat (20) @(posedge clk);
        chk("tick stopped", tickNum, n);
        for (k = 0; k < 32; k++)
        begin
            wr(SEL, 8'(k));
            repeat (2) @(posedge clk);
            p = k[3:1] + (k[3:1] >= 3) + (k[3:1] >= 6);
            if (k > 15)
                chk("pair", {channelPos, channelNeg, gainHigh}, {4'(p), 4'(p + 1), k[0]});
            else
                chk("single", {k < 11 ? channelPos : 4'h0, channelNeg}, {4'(k < 11 ? k : 0), 4'h0});
            chk("source", sourceKind, k > 15 ? 6 : (k < 11 ? 0 : k - 10));
        end
        for (k = 0; k < 8; k++)
        begin
            wr(MISC, 8'(k[2]) << 2);
            wr(SEL, 8'(k[1:0]) << 6);
            repeat (2) @(posedge clk);
            chk("ref", referenceKind, k[2] ? 1 : (k[0] ? 2 + k[1] : 0));
        end
        wr(MISC, 8'h00);
        wr(SEL, 8'h00);
        sample <= 10'($random(seed));
        wr(CSA, 8'hc9);
        rc(CSA, 8'hc9);
        chk("ext", extendedConversion, 1);
        idle();
        res = sample;
        chk("ticks", tickCount, 25);
        rc(CSA, 8'h99);
        chk("irq", conversionIrq, 1);
        globalIrqEnable <= 1'b0;
        repeat (2) @(posedge clk);
        chk("irq", conversionIrq, 0);
        globalIrqEnable <= 1'b1;
        rc(LO, res[7:0]);
        rc(HI, {6'h0, res[9:8]});
        wr(SEL, 8'h20);
        rc(LO, {res[1:0], 6'h0});
        rc(HI, res[9:2]);
        irqVectorTaken <= 1'b1;
        @(posedge clk);
        irqVectorTaken <= 1'b0;
        rc(CSA, 8'h89);
        sample <= 10'($random(seed));
        wr(CSA, 8'hc9);
        wr(SEL, 8'h73);
        repeat (2) @(posedge clk);
        chk("held sel", {referenceKind, sourceKind, channelPos}, 9'h0);
        idle();
        res2 = sample;
        chk("ticks", tickCount, 13);
        chk("new ref", {referenceKind, sourceKind}, {2'h2, 3'h6});
        chk("new pair", {channelPos, channelNeg, gainHigh}, {4'h1, 4'h2, 1'b1});
        rc(LO, {res2[1:0], 6'h0});
        sample <= 10'($random(seed));
        wr(CSA, 8'hc9);
        idle();
        chk("ticks", tickCount, 25);
        rc(HI, res2[9:2]);
        rd(CSA);
        wr(CSA, rv);
        rc(CSA, 8'h89);
        chk("starts", startCount, 3);
        wr(CSA, 8'hc1);
        wr(CSA, 8'h00);
        repeat (2) @(posedge clk);
        chk("active", conversionActive, 0);
        rc(CSA, 8'h00);
        wr(CSA, 8'ha1);
        for (k = 1; k < 8; k++)
        begin
            wr(CSB, 8'(k));
            n = startCount;
            triggerIn <= 7'(1 << (k - 1));
            @(posedge clk);
            triggerIn <= 7'h0;
            repeat (3) @(posedge clk);
            idle();
            chk("trigger", startCount, n + 1);
        end
        wr(CSB, 8'h00);
        n = startCount;
        wr(CSA, 8'he1);
        while (startCount < n + 3) @(posedge clk);
        wr(CSA, 8'h00);
        chk("free run", startCount, n + 3);
        complete_run();
    end
endmodule
`default_nettype wire
